// *** inc/atc_pkg.sv ***
// shared constants, register map and types of the absolute turn counter
package atc_pkg;
  // clock and link timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BAUD_BPS = 9600;
  localparam int unsigned GAP_MS = 50;
  localparam int unsigned BAUD_CYCLES = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
  localparam int unsigned GAP_CYCLES = (CLK_HZ / 1000) * GAP_MS;

  // counter limits and reset values
  localparam logic [15:0] LIMIT_DEFAULT = 16'hFFFF;
  localparam logic [15:0] POS_MAX = 16'h7FFF;
  localparam logic [15:0] NEG_WRAP = 16'h8001;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PULSES_RESET = 16'h0000;
  localparam logic USAGE_RESET = 1'b0;

  // report characters, 8 per frame
  localparam logic [2:0] LAST_CHAR = 3'h7;
  localparam logic [6:0] CH_P = 7'h50;
  localparam logic [6:0] CH_PLUS = 7'h2B;
  localparam logic [6:0] CH_MINUS = 7'h2D;
  localparam logic [6:0] CH_ZERO = 7'h30;
  localparam logic [6:0] CH_CR = 7'h0D;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LIMIT = 8'h04;
  localparam logic [7:0] REG_ACTIVE = 8'h08;
  localparam logic [7:0] REG_ENC = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_CMD = 8'h18;
  localparam logic [7:0] REG_PULSES = 8'h1C;

  // field positions
  localparam int unsigned CTRL_USAGE_BIT = 0;
  localparam int unsigned CMD_WRITE_BIT = 0;
  localparam int unsigned CMD_POWER_BIT = 1;

  // synchroniser lanes of the pin inputs
  localparam int unsigned PIN_REQ = 0;
  localparam int unsigned PIN_SON = 1;
  localparam int unsigned PIN_FWD = 2;
  localparam int unsigned PIN_REV = 3;
  localparam int unsigned PIN_INC = 4;
  localparam int unsigned PIN_COUNT = 5;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEND = 4'h2,
    ST_WAITC = 4'h4,
    ST_GAP = 4'h8
  } atc_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_SHIFT = 2'h2
  } atc_tx_state_t;

  // alarm code lines, low means ON
  typedef struct packed {
    logic bit3;
    logic bit2;
    logic bit1;
  } atc_alarm_t;

  localparam atc_alarm_t ALARM_NONE = '{bit3: 1'b1, bit2: 1'b1, bit1: 1'b1};
  localparam atc_alarm_t ALARM_MISMATCH = '{bit3: 1'b0, bit2: 1'b1, bit1: 1'b0};

  typedef struct packed {
    logic motorEnable;
    logic txDone;
    logic busy;
    logic alarm;
  } atc_status_t;
endpackage : atc_pkg

// *** verilog/atc_serial_tx.sv ***
// async character transmitter: start, 7 data bits lsb first, even parity, stop
`timescale 1ns/1ps
`default_nettype none
module atc_serial_tx (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic bitTick,
  input wire logic startTx,
  input wire logic [6:0] txChar,
  output logic txBusy,
  output logic txLine
);
  atc_pkg::atc_tx_state_t state_reg;
  logic [9:0] shift_reg;
  logic [3:0] bitCnt_reg;

  // start bit goes out at once; the divider is restarted by the caller
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= atc_pkg::TX_IDLE;
      shift_reg <= 10'h3FF;
      bitCnt_reg <= 4'h0;
      txLine <= 1'b1;
    end else begin
      case (state_reg)
        atc_pkg::TX_IDLE: begin
          txLine <= 1'b1;
          if (startTx) begin
            shift_reg <= {1'b1, ^txChar, txChar, 1'b0};
            bitCnt_reg <= 4'h0;
            txLine <= 1'b0;
            state_reg <= atc_pkg::TX_SHIFT;
          end
        end
        atc_pkg::TX_SHIFT: begin
          if (bitTick) begin
            if (bitCnt_reg == 4'h9) begin
              state_reg <= atc_pkg::TX_IDLE; // stop bit has had its full period
              txLine <= 1'b1;
            end else begin
              bitCnt_reg <= bitCnt_reg + 4'h1;
              txLine <= shift_reg[bitCnt_reg + 4'h1];
            end
          end
        end
        default: state_reg <= atc_pkg::TX_IDLE;
      endcase
    end
  end

  assign txBusy = (state_reg == atc_pkg::TX_SHIFT);
endmodule : atc_serial_tx
`default_nettype wire

// *** verilog/atc_turn_counter.sv ***
// multi-turn counter, turn limit handling, position request report and apb registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - default limit 65535 gives a signed count from -32767 to +32767
// - passing +32767 upward jumps to -32767, then counts up toward zero
// - passing -32767 downward jumps to +32767, then counts down toward zero
// - other limits count 0 up to limit, then back to zero
// - a new turn limit acts only after a power cycle
// - after a power cycle, limit differing from encoder's raises mismatch alarm
// - limit write into encoder accepted only during mismatch alarm
// - usage select 0 means absolute encoder, 1 means incremental
// - request rising edge sends multi-turn data then initial incremental pulses
// - motor stays inhibited until transmission completes, servo-on ignored meanwhile
// - normal incremental output resumes about 50ms after the last byte
// - report is 9600bps async, one start, one stop, even parity, 7-bit
module atc_turn_counter #(
  parameter int unsigned BAUD_CYCLES = atc_pkg::BAUD_CYCLES,
  parameter int unsigned GAP_CYCLES = atc_pkg::GAP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic positionRequest,
  input wire logic servoOn,
  input wire logic revFwdPulse,
  input wire logic revRevPulse,
  input wire logic incPhaseA,
  output logic phaseASerialOut,
  output logic motorEnable,
  output atc_pkg::atc_alarm_t alarmCode
);
  localparam int BW = $clog2(BAUD_CYCLES + 1);
  localparam int GW = $clog2(GAP_CYCLES + 1);

  // pin synchronisers
  logic [atc_pkg::PIN_COUNT-1:0] pinMeta_reg;
  logic [atc_pkg::PIN_COUNT-1:0] pinSync_reg;
  logic [atc_pkg::PIN_COUNT-1:0] pinLast_reg;

  // configuration and state
  logic usageIncr_reg;
  logic [15:0] limitSetting_reg;
  logic [15:0] activeLimit_reg;
  logic [15:0] encLimit_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] initPulses_reg;
  logic alarm_reg;
  logic txDone_reg;

  // report sequencer
  atc_pkg::atc_state_t state_reg;
  logic [2:0] charIdx_reg;
  logic snapNeg_reg;
  logic [15:0] snapMag_reg;
  logic [GW-1:0] gapCnt_reg;
  logic [15:0] pulseLeft_reg;
  logic pulsePhase_reg;
  logic [BW-1:0] baudCnt_reg;

  // bus answer and outputs
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic phaseAOut_reg;
  logic motorEnable_reg;
  atc_pkg::atc_alarm_t alarmCode_reg;

  logic [31:0] rdData;
  logic txBusy;
  logic txLine;

  // decimal digit of a magnitude, position 0 is the most significant of five
  function automatic logic [6:0] digitAt(input logic [15:0] mag, input logic [2:0] pos);
    logic [15:0] q;
    q = 16'h0000;
    case (pos)
      3'h0: q = mag / 16'd10000;
      3'h1: q = mag / 16'd1000;
      3'h2: q = mag / 16'd100;
      3'h3: q = mag / 16'd10;
      default: q = mag;
    endcase
    return atc_pkg::CH_ZERO + 7'(q % 16'd10);
  endfunction : digitAt

  // character of the report frame "P+nnnnn<cr>"
  function automatic logic [6:0] charAt(input logic [2:0] idx, input logic neg, input logic [15:0] mag);
    logic [6:0] c;
    c = atc_pkg::CH_CR;
    if (idx == 3'h0) begin
      c = atc_pkg::CH_P;
    end else if (idx == 3'h1) begin
      c = neg ? atc_pkg::CH_MINUS : atc_pkg::CH_PLUS;
    end else if (idx != atc_pkg::LAST_CHAR) begin
      c = digitAt(mag, idx - 3'h2);
    end
    return c;
  endfunction : charAt

  // edges and levels seen after the synchronisers
  wire reqRise = pinSync_reg[atc_pkg::PIN_REQ] & ~pinLast_reg[atc_pkg::PIN_REQ];
  wire fwdRise = pinSync_reg[atc_pkg::PIN_FWD] & ~pinLast_reg[atc_pkg::PIN_FWD];
  wire revRise = pinSync_reg[atc_pkg::PIN_REV] & ~pinLast_reg[atc_pkg::PIN_REV];
  wire stepUp = fwdRise & ~revRise;
  wire stepDn = revRise & ~fwdRise;

  // address decode
  wire hitCtrl = (paddr == atc_pkg::REG_CTRL);
  wire hitLimit = (paddr == atc_pkg::REG_LIMIT);
  wire hitActive = (paddr == atc_pkg::REG_ACTIVE);
  wire hitEnc = (paddr == atc_pkg::REG_ENC);
  wire hitCount = (paddr == atc_pkg::REG_COUNT);
  wire hitStatus = (paddr == atc_pkg::REG_STATUS);
  wire hitCmd = (paddr == atc_pkg::REG_CMD);
  wire hitPulses = (paddr == atc_pkg::REG_PULSES);
  wire mapped = hitCtrl | hitLimit | hitActive | hitEnc | hitCount | hitStatus | hitCmd | hitPulses;

  // one wait state: answer is registered, a write lands on the completing edge
  wire apbAccess = psel & penable & ~pready_reg;
  wire wrEn = psel & penable & pready_reg & pwrite & mapped;
  wire wrCtrl = wrEn & hitCtrl;
  wire wrLimit = wrEn & hitLimit;
  wire wrPulses = wrEn & hitPulses;
  wire powerCycle = wrEn & hitCmd & pwdata[atc_pkg::CMD_POWER_BIT];
  wire limitWrite = wrEn & hitCmd & pwdata[atc_pkg::CMD_WRITE_BIT] & alarm_reg & ~powerCycle;

  // counting mode and report snapshot
  wire defaultMode = (activeLimit_reg == atc_pkg::LIMIT_DEFAULT);
  wire curNeg = defaultMode & count_reg[15];
  wire [15:0] curMag = curNeg ? 16'(-count_reg) : count_reg;
  wire inSerial = (state_reg == atc_pkg::ST_SEND) | (state_reg == atc_pkg::ST_WAITC);
  wire inGap = (state_reg == atc_pkg::ST_GAP);
  wire startTx = (state_reg == atc_pkg::ST_SEND) & ~txBusy;
  wire bitTick = (baudCnt_reg == BW'(BAUD_CYCLES - 1));
  wire gapEnd = (gapCnt_reg == GW'(GAP_CYCLES - 1));
  wire [6:0] txChar = charAt(charIdx_reg, snapNeg_reg, snapMag_reg);

  atc_pkg::atc_status_t status;
  assign status.motorEnable = motorEnable_reg;
  assign status.txDone = txDone_reg;
  assign status.busy = (state_reg != atc_pkg::ST_IDLE);
  assign status.alarm = alarm_reg;

  // read mux; reserved bits read zero
  always_comb begin
    rdData = 32'h0000_0000;
    if (hitCtrl) begin
      rdData[atc_pkg::CTRL_USAGE_BIT] = usageIncr_reg;
    end else if (hitLimit) begin
      rdData[15:0] = limitSetting_reg;
    end else if (hitActive) begin
      rdData[15:0] = activeLimit_reg;
    end else if (hitEnc) begin
      rdData[15:0] = encLimit_reg;
    end else if (hitCount) begin
      rdData[15:0] = count_reg;
    end else if (hitStatus) begin
      rdData[3:0] = status;
    end else if (hitPulses) begin
      rdData[15:0] = initPulses_reg;
    end
  end

  // next turn count, one step per revolution edge
  always_comb begin
    count_next = count_reg;
    if (stepUp) begin
      if (defaultMode) begin
        count_next = (count_reg == atc_pkg::POS_MAX) ? atc_pkg::NEG_WRAP : count_reg + 16'h0001;
      end else begin
        count_next = (count_reg >= activeLimit_reg) ? 16'h0000 : count_reg + 16'h0001;
      end
    end else if (stepDn) begin
      if (defaultMode) begin
        count_next = (count_reg == atc_pkg::NEG_WRAP) ? atc_pkg::POS_MAX : count_reg - 16'h0001;
      end else begin
        count_next = (count_reg == 16'h0000) ? activeLimit_reg : count_reg - 16'h0001;
      end
    end
  end

  // two flops per pin, a third stage only for edge detection
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
      pinLast_reg <= '0;
    end else begin
      pinMeta_reg <= {incPhaseA, revRevPulse, revFwdPulse, servoOn, positionRequest};
      pinSync_reg <= pinMeta_reg;
      pinLast_reg <= pinSync_reg;
    end
  end

  // apb answer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      // answer stands one cycle only, so error and data drop together with ready
      pready_reg <= apbAccess;
      pslverr_reg <= apbAccess & ~mapped;
      prdata_reg <= (apbAccess && !pwrite) ? rdData : 32'h0000_0000;
    end
  end

  // software settings; the limit setting is only staged here
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      usageIncr_reg <= atc_pkg::USAGE_RESET;
      limitSetting_reg <= atc_pkg::LIMIT_DEFAULT;
      initPulses_reg <= atc_pkg::PULSES_RESET;
    end else begin
      if (wrCtrl) begin
        usageIncr_reg <= pwdata[atc_pkg::CTRL_USAGE_BIT];
      end
      if (wrLimit) begin
        limitSetting_reg <= pwdata[15:0];
      end
      if (wrPulses) begin
        initPulses_reg <= pwdata[15:0];
      end
    end
  end

  // power cycle commits the limit and compares it with the encoder's
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      activeLimit_reg <= atc_pkg::LIMIT_DEFAULT;
      encLimit_reg <= atc_pkg::LIMIT_DEFAULT;
      alarm_reg <= 1'b0;
      count_reg <= atc_pkg::COUNT_RESET;
    end else begin
      count_reg <= count_next;
      if (powerCycle) begin
        activeLimit_reg <= limitSetting_reg;
        alarm_reg <= (limitSetting_reg != encLimit_reg);
      end
      if (limitWrite) begin
        encLimit_reg <= activeLimit_reg;
      end
    end
  end

  // baud divider, restarted with each character so bit one is full length
  always_ff @(posedge sys_clk) begin
    if (sys_rst || startTx || bitTick) begin
      baudCnt_reg <= '0;
    end else begin
      baudCnt_reg <= baudCnt_reg + BW'(1);
    end
  end

  // report sequence: eight characters, then pulses inside the settle gap
  always_ff @(posedge sys_clk) begin
    if (sys_rst || powerCycle) begin
      state_reg <= atc_pkg::ST_IDLE;
      charIdx_reg <= 3'h0;
      snapNeg_reg <= 1'b0;
      snapMag_reg <= 16'h0000;
      gapCnt_reg <= '0;
      pulseLeft_reg <= 16'h0000;
      pulsePhase_reg <= 1'b0;
      txDone_reg <= 1'b0;
    end else begin
      case (state_reg)
        atc_pkg::ST_IDLE: begin
          if (reqRise && !usageIncr_reg) begin
            state_reg <= atc_pkg::ST_SEND;
            charIdx_reg <= 3'h0;
            snapNeg_reg <= curNeg;
            snapMag_reg <= curMag;
            txDone_reg <= 1'b0;
          end
        end
        atc_pkg::ST_SEND: begin
          if (!txBusy) begin
            state_reg <= atc_pkg::ST_WAITC;
          end
        end
        atc_pkg::ST_WAITC: begin
          if (!txBusy) begin
            if (charIdx_reg == atc_pkg::LAST_CHAR) begin
              state_reg <= atc_pkg::ST_GAP;
              gapCnt_reg <= '0;
              pulseLeft_reg <= initPulses_reg;
            end else begin
              charIdx_reg <= charIdx_reg + 3'h1;
              state_reg <= atc_pkg::ST_SEND;
            end
          end
        end
        atc_pkg::ST_GAP: begin
          gapCnt_reg <= gapCnt_reg + GW'(1);
          if (bitTick && pulseLeft_reg != 16'h0000) begin
            pulsePhase_reg <= ~pulsePhase_reg;
            if (pulsePhase_reg) begin
              pulseLeft_reg <= pulseLeft_reg - 16'h0001;
            end
          end
          if (gapEnd) begin
            state_reg <= atc_pkg::ST_IDLE;
            pulsePhase_reg <= 1'b0;
            txDone_reg <= 1'b1;
          end
        end
        default: state_reg <= atc_pkg::ST_IDLE;
      endcase
    end
  end

  // registered outputs; servo-on counts only once the report is out, or at once in incremental use
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phaseAOut_reg <= 1'b1;
      motorEnable_reg <= 1'b0;
      alarmCode_reg <= atc_pkg::ALARM_NONE;
    end else begin
      phaseAOut_reg <= inSerial ? txLine : (inGap ? pulsePhase_reg : pinSync_reg[atc_pkg::PIN_INC]);
      motorEnable_reg <= pinSync_reg[atc_pkg::PIN_SON] & (usageIncr_reg | txDone_reg);
      alarmCode_reg <= alarm_reg ? atc_pkg::ALARM_MISMATCH : atc_pkg::ALARM_NONE;
    end
  end

  atc_serial_tx u_tx (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .bitTick(bitTick),
    .startTx(startTx),
    .txChar(txChar),
    .txBusy(txBusy),
    .txLine(txLine)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign phaseASerialOut = phaseAOut_reg;
  assign motorEnable = motorEnable_reg;
  assign alarmCode = alarmCode_reg;
endmodule : atc_turn_counter
`default_nettype wire

// *** verif/atc_turn_counter_props.sv ***
// checker: port-level assertions of the absolute turn counter
`timescale 1ns/1ps
`default_nettype none
module atc_turn_counter_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic servoOn,
  input wire logic phaseASerialOut,
  input wire logic motorEnable,
  input wire atc_pkg::atc_alarm_t alarmCode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // access phase still waiting, and servo-on held low past the synchroniser
  sequence acc_wait;
    psel && penable && !pready;
  endsequence
  sequence no_servo;
    !servoOn [*6];
  endsequence

  // reset must leave the motor off and the alarm lines released
  rst_values_a: assert property (disable iff (1'b0) sys_rst |=> !motorEnable && !pready && phaseASerialOut
    && alarmCode == atc_pkg::ALARM_NONE) else $error("outputs not at reset values");
  pready_wait_a: assert property (acc_wait |=> pready) else $error("no answer after one wait state");
  pready_pulse_a: assert property (pready |=> !pready) else $error("ready held longer than one cycle");
  pready_phase_a: assert property (pready |-> psel && penable) else $error("ready outside access phase");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
  // only two codes exist; any other mix would mislead the host
  alarm_code_a: assert property (alarmCode == atc_pkg::ALARM_NONE || alarmCode == atc_pkg::ALARM_MISMATCH)
    else $error("illegal alarm code");
  motor_inhibit_a: assert property (no_servo |=> !motorEnable)
    else $error("motor enabled without servo on");
endmodule : atc_turn_counter_props
`default_nettype wire

// *** verif/atc_host_model.sv ***
// host controller model: drives the position request and decodes the report
`timescale 1ns/1ps
`default_nettype none
module atc_host_model #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic sys_clk,
  input wire logic rxLine,
  output logic positionRequest
);
  logic [6:0] chars [8];
  int parityErr = 0;

  // held low from power-on until the bench has settled the device
  initial positionRequest = 1'b0;

  // line low before a power cycle, so the device starts from a quiet request
  task lower;
    @(posedge sys_clk);
    positionRequest <= 1'b0;
  endtask : lower

  // drop and re-raise; the hold is scaled down from the real seconds
  task raise;
    @(posedge sys_clk);
    positionRequest <= 1'b0;
    repeat (20) @(posedge sys_clk);
    positionRequest <= 1'b1;
  endtask : raise

  // samples mid-bit; stops at the stop bit so the next start is not skipped
  task fetch;
    logic [9:0] sh;
    int w;
    raise();
    for (int c = 0; c < 8; c++) begin
      w = 0;
      while (rxLine !== 1'b0 && w < 4000) begin
        @(posedge sys_clk);
        w++;
      end
      repeat (BIT_CYCLES / 2) @(posedge sys_clk);
      for (int b = 0; b < 10; b++) begin
        sh[b] = rxLine;
        if (b < 9) repeat (BIT_CYCLES) @(posedge sys_clk);
      end
      chars[c] = sh[7:1];
      if (^sh[8:1] !== 1'b0 || sh[9] !== 1'b1) parityErr++;
    end
  endtask : fetch
endmodule : atc_host_model
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking testbench of the absolute turn counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, sys_rst, psel, penable, pwrite, servoOn, revFwdPulse, revRevPulse, incPhaseA;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, positionRequest, phaseASerialOut, motorEnable, er;
  atc_pkg::atc_alarm_t alarmCode;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  atc_turn_counter #(.BAUD_CYCLES(8), .GAP_CYCLES(400)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .positionRequest(positionRequest), .servoOn(servoOn),
    .revFwdPulse(revFwdPulse), .revRevPulse(revRevPulse), .incPhaseA(incPhaseA),
    .phaseASerialOut(phaseASerialOut), .motorEnable(motorEnable), .alarmCode(alarmCode));
  atc_host_model #(.BIT_CYCLES(8)) host (.sys_clk(sys_clk), .rxLine(phaseASerialOut),
    .positionRequest(positionRequest));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // hang guard: wrap test alone needs about 66k cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt++;
      complete_run();
    end
  end

  task complete_run;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // apb master: request held until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // one cycle high, one low per revolution, then let the synchroniser drain
  task turn(input logic fwd, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (fwd) revFwdPulse <= 1'b1;
      else revRevPulse <= 1'b1;
      @(posedge sys_clk);
      revFwdPulse <= 1'b0;
      revRevPulse <= 1'b0;
    end
    repeat (6) @(posedge sys_clk);
  endtask : turn

  task report(input string s);
    int n;
    host.fetch();
    for (int i = 0; i < 7; i++) chk(host.chars[i], s[i]);
    chk(host.chars[7], 32'h0D);
    chk(host.parityErr, 0);
    chk(motorEnable, 1'b0);
    n = 0;
    do begin
      apb(1'b0, atc_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[2] !== 1'b1 && n < 300);
    chk(rd[2], 1'b1);
    repeat (8) @(posedge sys_clk);
    chk(motorEnable, 1'b1);
    incPhaseA <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(phaseASerialOut, 1'b0);
    incPhaseA <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : report

  task t_regs;
    chk(motorEnable, 1'b0);
    rdchk(atc_pkg::REG_LIMIT, 32'h0000FFFF);
    rdchk(atc_pkg::REG_ACTIVE, 32'h0000FFFF);
    rdchk(atc_pkg::REG_ENC, 32'h0000FFFF);
    rdchk(atc_pkg::REG_COUNT, 32'h00000000);
    rdchk(atc_pkg::REG_CTRL, 32'h00000000);
    rdchk(atc_pkg::REG_STATUS, 32'h00000000);
    rdchk(8'h20, 32'h00000000);
    chk(er, 1'b1);
    chk(alarmCode, atc_pkg::ALARM_NONE);
  endtask : t_regs

  task t_wrap;
    turn(1'b1, 32767);
    rdchk(atc_pkg::REG_COUNT, 32'h00007FFF);
    turn(1'b1, 1);
    rdchk(atc_pkg::REG_COUNT, 32'h00008001);
    report("P-32767");
    turn(1'b0, 1);
    rdchk(atc_pkg::REG_COUNT, 32'h00007FFF);
  endtask : t_wrap

  task t_limit;
    host.lower();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b1, atc_pkg::REG_LIMIT, 32'h3);
    rdchk(atc_pkg::REG_ACTIVE, 32'h0000FFFF);
    turn(1'b0, 1);
    rdchk(atc_pkg::REG_COUNT, 32'h0000FFFF);
    turn(1'b1, 1);
    apb(1'b1, atc_pkg::REG_CMD, 32'h1);
    rdchk(atc_pkg::REG_ENC, 32'h0000FFFF);
    apb(1'b1, atc_pkg::REG_CMD, 32'h2);
    rdchk(atc_pkg::REG_ACTIVE, 32'h3);
    rdchk(atc_pkg::REG_STATUS, 32'h1);
    chk(alarmCode, atc_pkg::ALARM_MISMATCH);
    turn(1'b1, 3);
    rdchk(atc_pkg::REG_COUNT, 32'h3);
    turn(1'b1, 1);
    rdchk(atc_pkg::REG_COUNT, 32'h0);
    turn(1'b0, 1);
    rdchk(atc_pkg::REG_COUNT, 32'h3);
    rdchk(atc_pkg::REG_LIMIT, 32'h3);
    apb(1'b1, atc_pkg::REG_CMD, 32'h1);
    rdchk(atc_pkg::REG_ENC, 32'h3);
    apb(1'b1, atc_pkg::REG_CMD, 32'h2);
    rdchk(atc_pkg::REG_STATUS, 32'h0);
    chk(alarmCode, atc_pkg::ALARM_NONE);
  endtask : t_limit

  // incremental use: request ignored, servo-on passes straight through
  task t_incr;
    int lows;
    apb(1'b1, atc_pkg::REG_CTRL, 32'h1);
    repeat (8) @(posedge sys_clk);
    chk(motorEnable, 1'b1);
    host.raise();
    lows = 0;
    repeat (200) begin
      @(posedge sys_clk);
      if (phaseASerialOut !== 1'b1) lows++;
    end
    chk(lows, 0);
    rdchk(atc_pkg::REG_STATUS, 32'h8);
    servoOn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(motorEnable, 1'b0);
  endtask : t_incr

  // main sequence
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    servoOn = 1'b1;
    revFwdPulse = 1'b0;
    revRevPulse = 1'b0;
    incPhaseA = 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    report("P+00000");
    t_wrap();
    t_limit();
    t_incr();
    complete_run();
  end
endmodule : tb_top

bind atc_turn_counter atc_turn_counter_props props (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .servoOn(servoOn),
  .phaseASerialOut(phaseASerialOut), .motorEnable(motorEnable), .alarmCode(alarmCode));
`default_nettype wire
